/* acm_pkg.sv */
package acm_pkg;

	// register byte addresses on the control bus
	localparam logic [7:0] ADDR_MST_CFG  = 8'h13;
	localparam logic [7:0] ADDR_RATE_CFG = 8'h14;
	localparam logic [7:0] ADDR_STATUS   = 8'h15;
	localparam logic [7:0] ADDR_ROOT_CLOCK_SOURCE_CONFIG  = 8'h16;

	// reset values, and the value read at unmapped addresses
	localparam logic [7:0] RST_MST_CFG  = 8'h02;
	localparam logic [7:0] RST_RATE_CFG = 8'h48;
	localparam logic [7:0] RST_STATUS   = 8'hff;
	localparam logic [7:0] RST_ROOT_CLOCK_SOURCE_CONFIG  = 8'h10;
	localparam logic [7:0] RD_UNMAPPED  = 8'h00;

	// code limits
	localparam logic [3:0] CODE_INVALID   = 4'hf;
	localparam logic [3:0] RATE_CODE_MAX  = 4'h8;
	localparam logic [3:0] RATIO_CODE_MAX = 4'hc;
	localparam int         RATE_CODES     = 9;
	localparam int         RATIO_CODES    = 13;

	// 44.1 kHz family is the 48 kHz family scaled by 147/160
	localparam longint FAM44_NUM  = 147;
	localparam longint FAM44_DEN  = 160;
	// detection window is +/- 1/32 around the two family periods
	localparam longint MARGIN_DEN = 32;

	// control bus framing
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic       BUS_READ = 1'b1;

	// master clock configuration register layout
	typedef struct packed {
		logic       master_slave_select;
		logic       auto_cfg_disable;
		logic       auto_pll_bypass;
		logic       clock_gate;
		logic       family_44k1;
		logic [2:0] refclk_freq_select;
	} acm_mst_cfg_t;

	// rate and ratio pair, used for programmed and detected values
	typedef struct packed {
		logic [3:0] rate;
		logic [3:0] ratio;
	} acm_rate_pair_t;

	// root clock source register layout
	typedef struct packed {
		logic       pll_off_root_select;
		logic       refclk_freq_mode;
		logic [2:0] refclk_ratio_select;
		logic       rsv2;
		logic       invert_bitclk_for_sync;
		logic       rsv0;
	} acm_root_clock_source_config_t;

	typedef enum logic [1:0] {
		ACM_ROOT_PLL    = 2'b00,
		ACM_ROOT_BITCLK = 2'b01,
		ACM_ROOT_REFCLK = 2'b10
	} acm_root_t;

	// 48 kHz family frame rate in Hz, zero for reserved codes
	function automatic longint acm_rate_hz(input logic [3:0] code);
		case (code)
			4'h0:    acm_rate_hz = 8000;
			4'h1:    acm_rate_hz = 16000;
			4'h2:    acm_rate_hz = 24000;
			4'h3:    acm_rate_hz = 32000;
			4'h4:    acm_rate_hz = 48000;
			4'h5:    acm_rate_hz = 96000;
			4'h6:    acm_rate_hz = 192000;
			4'h7:    acm_rate_hz = 384000;
			4'h8:    acm_rate_hz = 768000;
			default: acm_rate_hz = 0;
		endcase
	endfunction : acm_rate_hz

	// bit clock periods per frame, zero for reserved codes
	function automatic logic [11:0] acm_ratio_value(input logic [3:0] code);
		case (code)
			4'h0:    acm_ratio_value = 12'h010;
			4'h1:    acm_ratio_value = 12'h018;
			4'h2:    acm_ratio_value = 12'h020;
			4'h3:    acm_ratio_value = 12'h030;
			4'h4:    acm_ratio_value = 12'h040;
			4'h5:    acm_ratio_value = 12'h060;
			4'h6:    acm_ratio_value = 12'h080;
			4'h7:    acm_ratio_value = 12'h0c0;
			4'h8:    acm_ratio_value = 12'h100;
			4'h9:    acm_ratio_value = 12'h180;
			4'ha:    acm_ratio_value = 12'h200;
			4'hb:    acm_ratio_value = 12'h400;
			4'hc:    acm_ratio_value = 12'h800;
			default: acm_ratio_value = 12'h000;
		endcase
	endfunction : acm_ratio_value

	// reference clock periods per frame
	function automatic logic [11:0] acm_refclk_ratio(input logic [2:0] code);
		case (code)
			3'h0:    acm_refclk_ratio = 12'h040;
			3'h1:    acm_refclk_ratio = 12'h100;
			3'h2:    acm_refclk_ratio = 12'h180;
			3'h3:    acm_refclk_ratio = 12'h200;
			3'h4:    acm_refclk_ratio = 12'h300;
			3'h5:    acm_refclk_ratio = 12'h400;
			3'h6:    acm_refclk_ratio = 12'h600;
			default: acm_refclk_ratio = 12'h900;
		endcase
	endfunction : acm_refclk_ratio

endpackage : acm_pkg

/* acm_bus_monitor.sv */
`timescale 1ns/10ps
module acm_bus_monitor #(
	parameter longint CLK_HZ = 50000000,
	parameter int     CNT_W  = 16
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    bclk_lvl,
	input  wire logic                    frame_sync_lvl,
	output acm_pkg::acm_rate_pair_t      detected
);
	import acm_pkg::*;

	// slowest frame of the 44.1 family plus margin; beyond this the bus is dead
	localparam longint TIMEOUT_L = (CLK_HZ * FAM44_DEN * (MARGIN_DEN + 1))
		/ (acm_rate_hz(4'h0) * FAM44_NUM * MARGIN_DEN) + 1;
	localparam logic [CNT_W-1:0] TIMEOUT = TIMEOUT_L[CNT_W-1:0];

	logic                 bclk_d;
	logic                 frame_sync_d;
	logic [CNT_W-1:0]     frame_cyc;
	logic [CNT_W-1:0]     bit_cnt;
	acm_rate_pair_t       next_detected;
	logic [CNT_W-1:0]     next_frame_cyc;
	logic [CNT_W-1:0]     next_bit_cnt;
	logic                 bclk_rise;
	logic                 frame_sync_rise;

	// frame length in reference cycles to a rate code, each code accepts both families
	function automatic logic [3:0] classify_rate(input logic [CNT_W-1:0] cyc);
		longint lo;
		longint hi;
		classify_rate = CODE_INVALID;
		for (int k = 0; k < RATE_CODES; k++) begin
			lo = (CLK_HZ * (MARGIN_DEN - 1)) / (acm_rate_hz(4'(k)) * MARGIN_DEN);
			hi = (CLK_HZ * FAM44_DEN * (MARGIN_DEN + 1))
				/ (acm_rate_hz(4'(k)) * FAM44_NUM * MARGIN_DEN);
			if (longint'(cyc) >= lo && longint'(cyc) <= hi) begin
				classify_rate = 4'(k);
			end
		end
	endfunction : classify_rate

	// exact bit clock count to a ratio code
	function automatic logic [3:0] classify_ratio(input logic [CNT_W-1:0] cnt);
		classify_ratio = CODE_INVALID;
		for (int k = 0; k < RATIO_CODES; k++) begin
			if (cnt == CNT_W'(acm_ratio_value(4'(k)))) begin
				classify_ratio = 4'(k);
			end
		end
	endfunction : classify_ratio

	assign bclk_rise  = bclk_lvl & ~bclk_d;
	assign frame_sync_rise = frame_sync_lvl & ~frame_sync_d;

	// measure between frame starts; a silent bus falls back to invalid
	always_comb begin
		next_detected  = detected;
		next_frame_cyc = frame_cyc;
		next_bit_cnt   = bit_cnt;
		if (frame_sync_rise) begin
			next_detected.rate  = classify_rate(frame_cyc);
			next_detected.ratio = classify_ratio(bit_cnt);
			next_frame_cyc      = '0;
			next_bit_cnt        = CNT_W'(bclk_rise);
		end else begin
			if (frame_cyc < TIMEOUT) begin
				next_frame_cyc = frame_cyc + 1'b1;
			end else begin
				next_detected = RST_STATUS;
			end
			if (bclk_rise && bit_cnt != '1) begin
				next_bit_cnt = bit_cnt + 1'b1;
			end
		end
	end

	// status starts as invalid until a frame has been measured
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			detected  <= RST_STATUS;
			frame_cyc <= '0;
			bit_cnt   <= '0;
			bclk_d    <= 1'b0;
			frame_sync_d   <= 1'b0;
		end else begin
			detected  <= next_detected;
			frame_cyc <= next_frame_cyc;
			bit_cnt   <= next_bit_cnt;
			bclk_d    <= bclk_lvl;
			frame_sync_d   <= frame_sync_lvl;
		end
	end

endmodule : acm_bus_monitor

/* acm_master_gen.sv */
`timescale 1ns/10ps
module acm_master_gen #(
	parameter longint CLK_HZ = 50000000
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  enable,
	input  acm_pkg::acm_rate_pair_t    prog,
	input  wire logic                  family_44k1,
	input  wire logic                  invert_sync,
	output logic                       bclk_q,
	output logic                       frame_sync_q
);
	import acm_pkg::*;

	logic [15:0] div_cnt;
	logic [11:0] bit_idx;
	logic [15:0] half;
	logic [11:0] ratio;
	logic [15:0] next_div_cnt;
	logic [11:0] next_bit_idx;
	logic        next_bclk;
	logic        next_frame_sync;

	// half bit period in reference cycles; coarse, limited by the reference rate
	function automatic logic [15:0] half_cycles(input acm_rate_pair_t p, input logic fam);
		longint hz;
		longint h;
		hz = acm_rate_hz(p.rate) * longint'(acm_ratio_value(p.ratio));
		if (fam) begin
			hz = (hz * FAM44_NUM) / FAM44_DEN;
		end
		h = (hz == 0) ? 1 : CLK_HZ / (2 * hz);
		half_cycles = (h < 1) ? 16'h0001 : (h > 65535) ? 16'hffff : h[15:0];
	endfunction : half_cycles

	assign half  = half_cycles(prog, family_44k1);
	assign ratio = acm_ratio_value(prog.ratio);

	// toggle the bit clock; frame sync moves on the falling edge, or rising when inverted
	always_comb begin
		next_div_cnt = div_cnt + 1'b1;
		next_bit_idx = bit_idx;
		next_bclk    = bclk_q;
		next_frame_sync   = frame_sync_q;
		if (!enable) begin
			next_div_cnt = '0;
			next_bit_idx = '0;
			next_bclk    = 1'b0;
			next_frame_sync   = 1'b0;
		end else if (div_cnt >= half - 1'b1) begin
			next_div_cnt = '0;
			next_bclk    = ~bclk_q;
			if (bclk_q) begin
				next_bit_idx = (bit_idx >= ratio - 1'b1) ? 12'h000 : bit_idx + 1'b1;
				if (!invert_sync) begin
					next_frame_sync = (next_bit_idx == 12'h000);
				end
			end else if (invert_sync) begin
				next_frame_sync = (bit_idx == 12'h000);
			end
		end
	end

	// divider and frame position registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div_cnt <= '0;
			bit_idx <= '0;
			bclk_q  <= 1'b0;
			frame_sync_q <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			bit_idx <= next_bit_idx;
			bclk_q  <= next_bclk;
			frame_sync_q <= next_frame_sync;
		end
	end

endmodule : acm_master_gen

/* acm_clock_config_monitor.sv */
// Operation
// - rate code 0..8 picks 8..768 kHz or 44.1 family; unused in slave auto
// - ratio code 0..12 picks 16..2048 bit clocks per frame; unused in slave auto
// - detected rate status uses same codes, 15 means invalid, resets to ones
// - detected ratio status uses same codes, 15 means invalid, resets to ones
// - pll off in slave auto: 0 takes bit clock, 1 takes reference clock
// - frequency mode 0 uses frequency select, 1 uses reference ratio field
// - reference ratio code 0..7 picks 64..2304, resets to code 2
// - invert bit makes frame sync follow the opposite bit clock edge
// - programmed rate resets to code 4 and ratio to code 8
// - select 0 makes bus clocks inputs, 1 makes the device drive them
// - pll bypass bit disables pll in auto mode, root select then applies in slave mode
`timescale 1ns/10ps
module acm_clock_config_monitor #(
	parameter longint     REF_CLK_HZ = 50000000,
	parameter logic [6:0] DEV_ADDR   = 7'h2a  // arbitrary bus address
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	input  wire logic               bclk_in,
	output logic                    bclk_out,
	output logic                    bclk_oe,
	input  wire logic               frame_sync_in,
	output logic                    frame_sync_out,
	output logic                    frame_sync_oe,
	output logic                    master_mode,
	output logic                    pll_enable,
	output acm_pkg::acm_root_t      root_src,
	output logic                    refclk_by_ratio,
	output logic [2:0]              refclk_freq_select,
	output logic [11:0]             refclk_ratio
);
	import acm_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_PTR       = 4'b0011,
		ST_PTR_ACK   = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RACK      = 4'b1000
	} acm_bus_st_t;

	// pin synchronisers; stage one feeds only stage two
	logic [2:0]     scl_s;
	logic [2:0]     sda_s;
	logic [1:0]     bclk_s;
	logic [1:0]     frame_sync_s;

	acm_bus_st_t    state;
	acm_bus_st_t    next_state;
	logic [2:0]     bit_cnt;
	logic [2:0]     next_bit_cnt;
	logic [7:0]     shreg;
	logic [7:0]     next_shreg;
	logic [7:0]     ptr;
	logic [7:0]     next_ptr;
	logic           rw;
	logic           next_rw;
	logic           ack_on;
	logic           next_ack_on;
	logic           sda_drive;
	logic           next_sda_drive;
	acm_mst_cfg_t   mst_cfg;
	acm_mst_cfg_t   next_mst_cfg;
	acm_rate_pair_t rate_cfg;
	acm_rate_pair_t next_rate_cfg;
	acm_root_clock_source_config_t   root_clock_source_config;
	acm_root_clock_source_config_t   next_root_clock_source_config;
	acm_rate_pair_t detected;

	logic           scl_rise;
	logic           scl_fall;
	logic           bus_start;
	logic           bus_stop;
	logic [7:0]     rx_byte;
	logic [7:0]     rd_byte;
	logic           auto_mode;
	logic           gen_enable;
	logic           gen_bclk;
	logic           gen_frame_sync;

	// register read mux; unmapped addresses read as zero
	function automatic logic [7:0] reg_read(input logic [7:0] a, input acm_mst_cfg_t m,
		input acm_rate_pair_t r, input acm_rate_pair_t s, input acm_root_clock_source_config_t c);
		case (a)
			ADDR_MST_CFG:  reg_read = m;
			ADDR_RATE_CFG: reg_read = r;
			ADDR_STATUS:   reg_read = s;
			ADDR_ROOT_CLOCK_SOURCE_CONFIG:  reg_read = c;
			default:       reg_read = RD_UNMAPPED;
		endcase
	endfunction : reg_read

	// edge and framing detection on the settled copies only
	assign scl_rise  = scl_s[1] & ~scl_s[2];
	assign scl_fall  = ~scl_s[1] & scl_s[2];
	assign bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	assign bus_stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
	assign rx_byte   = {shreg[6:0], sda_s[1]};
	assign rd_byte   = reg_read(ptr, mst_cfg, rate_cfg, detected, root_clock_source_config);

	// control bus slave: address, pointer byte, then auto-incrementing data
	always_comb begin
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_ptr       = ptr;
		next_rw        = rw;
		next_ack_on    = ack_on;
		next_sda_drive = sda_drive;
		next_mst_cfg   = mst_cfg;
		next_rate_cfg  = rate_cfg;
		next_root_clock_source_config   = root_clock_source_config;
		if (bus_start) begin
			next_state     = ST_ADDR;
			next_bit_cnt   = '0;
			next_ack_on    = 1'b0;
			next_sda_drive = 1'b0;
		end else if (bus_stop) begin
			next_state     = ST_IDLE;
			next_ack_on    = 1'b0;
			next_sda_drive = 1'b0;
		end else if (scl_rise) begin
			case (state)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					next_shreg   = rx_byte;
					next_bit_cnt = bit_cnt + 1'b1;
					if (bit_cnt == LAST_BIT) begin
						if (state == ST_ADDR) begin
							next_rw    = rx_byte[0];
							next_state = (rx_byte[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
						end else if (state == ST_PTR) begin
							next_ptr   = rx_byte;
							next_state = ST_PTR_ACK;
						end else begin
							// reserved bits are stored as written; host keeps them zero
							case (ptr)
								ADDR_MST_CFG:  next_mst_cfg  = rx_byte;
								ADDR_RATE_CFG: next_rate_cfg = rx_byte;
								ADDR_ROOT_CLOCK_SOURCE_CONFIG:  next_root_clock_source_config  = rx_byte;
								default:       next_ptr      = ptr;      // status is read only
							endcase
							next_ptr   = ptr + 1'b1;
							next_state = ST_WDATA_ACK;
						end
					end
				end
				ST_RDATA: begin
					next_shreg   = {shreg[6:0], 1'b0};
					next_bit_cnt = bit_cnt + 1'b1;
					if (bit_cnt == LAST_BIT) begin
						next_state = ST_RACK;
					end
				end
				ST_RACK: begin
					// host ack asks for the next byte, nack ends the read
					if (!sda_s[1]) begin
						next_shreg   = rd_byte;
						next_ptr     = ptr + 1'b1;
						next_bit_cnt = '0;
						next_state   = ST_RDATA;
					end else begin
						next_state = ST_IDLE;
					end
				end
				default: next_state = state;
			endcase
		end else if (scl_fall) begin
			case (state)
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
					if (!ack_on) begin
						next_ack_on    = 1'b1;
						next_sda_drive = 1'b1;
					end else begin
						next_ack_on    = 1'b0;
						next_sda_drive = 1'b0;
						next_bit_cnt   = '0;
						if (state == ST_ADDR_ACK && rw == BUS_READ) begin
							next_shreg     = rd_byte;
							next_ptr       = ptr + 1'b1;
							next_sda_drive = ~rd_byte[7];
							next_state     = ST_RDATA;
						end else begin
							next_state = (state == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
						end
					end
				end
				ST_RDATA: next_sda_drive = ~shreg[7];
				ST_RACK:  next_sda_drive = 1'b0;
				default:  next_sda_drive = 1'b0;
			endcase
		end
	end

	// bus slave and configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			bit_cnt   <= '0;
			shreg     <= '0;
			ptr       <= '0;
			rw        <= 1'b0;
			ack_on    <= 1'b0;
			sda_drive <= 1'b0;
			mst_cfg   <= RST_MST_CFG;
			rate_cfg  <= RST_RATE_CFG;
			root_clock_source_config   <= RST_ROOT_CLOCK_SOURCE_CONFIG;
			scl_s     <= 3'h7;
			sda_s     <= 3'h7;
			bclk_s    <= 2'h0;
			frame_sync_s   <= 2'h0;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shreg     <= next_shreg;
			ptr       <= next_ptr;
			rw        <= next_rw;
			ack_on    <= next_ack_on;
			sda_drive <= next_sda_drive;
			mst_cfg   <= next_mst_cfg;
			rate_cfg  <= next_rate_cfg;
			root_clock_source_config   <= next_root_clock_source_config;
			scl_s     <= {scl_s[1:0], scl_in};
			sda_s     <= {sda_s[1:0], sda_in};
			bclk_s    <= {bclk_s[0], bclk_in};
			frame_sync_s   <= {frame_sync_s[0], frame_sync_in};
		end
	end

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_drive;

	// clock tree selection; a disabled auto mode keeps the pll path
	assign auto_mode          = ~mst_cfg.auto_cfg_disable;
	assign master_mode        = mst_cfg.master_slave_select;
	assign pll_enable         = ~(auto_mode & mst_cfg.auto_pll_bypass);
	assign refclk_by_ratio    = root_clock_source_config.refclk_freq_mode;
	assign refclk_freq_select = mst_cfg.refclk_freq_select;
	assign refclk_ratio       = acm_refclk_ratio(root_clock_source_config.refclk_ratio_select);

	// master without pll runs from the reference clock
	always_comb begin
		if (pll_enable) begin
			root_src = ACM_ROOT_PLL;
		end else if (master_mode || root_clock_source_config.pll_off_root_select) begin
			root_src = ACM_ROOT_REFCLK;
		end else begin
			root_src = ACM_ROOT_BITCLK;
		end
	end

	// programmed codes only drive the generator in master mode; reserved codes idle it
	assign gen_enable = master_mode & ~mst_cfg.clock_gate
		& (rate_cfg.rate <= RATE_CODE_MAX) & (rate_cfg.ratio <= RATIO_CODE_MAX);

	acm_master_gen #(
		.CLK_HZ (REF_CLK_HZ)
	) u_gen (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.enable      (gen_enable),
		.prog        (rate_cfg),
		.family_44k1 (mst_cfg.family_44k1),
		.invert_sync (root_clock_source_config.invert_bitclk_for_sync),
		.bclk_q      (gen_bclk),
		.frame_sync_q     (gen_frame_sync)
	);

	// bus clocks are driven only as master
	assign bclk_out  = gen_bclk;
	assign frame_sync_out = gen_frame_sync;
	assign bclk_oe   = master_mode;
	assign frame_sync_oe  = master_mode;

	// the monitor watches the wire, so in master mode it sees our own clocks
	acm_bus_monitor #(
		.CLK_HZ (REF_CLK_HZ),
		.CNT_W  (16)
	) u_mon (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.bclk_lvl  (bclk_s[1]),
		.frame_sync_lvl (frame_sync_s[1]),
		.detected  (detected)
	);

endmodule : acm_clock_config_monitor

/* acm_bus_src.sv */
`timescale 1ns/10ps
// far end of the audio bus in slave mode: it owns both bus clocks
module acm_bus_src (
	input  wire logic        en,
	input  wire logic [11:0] ratio,
	output logic             bclk,
	output logic             frame_sync
);
	int n;
	// bit clock stands still low outside frames; sync high for the first bit
	initial begin
		bclk = 1'b0;
		frame_sync = 1'b0;
		forever begin
			if (en) begin
				for (n = 0; n < ratio; n++) begin
					frame_sync = (n == 0);
					#80 bclk = 1'b1;
					#80 bclk = 1'b0;
				end
			end else begin
				frame_sync = 1'b0;
				#80;
			end
		end
	end
endmodule : acm_bus_src

/* acm_checker.sv */
`timescale 1ns/10ps
module acm_checker
	import acm_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        bclk_out,
	input wire logic        bclk_oe,
	input wire logic        frame_sync_out,
	input wire logic        frame_sync_oe,
	input wire logic        master_mode,
	input wire logic        pll_enable,
	input acm_root_t        root_src,
	input wire logic [2:0]  refclk_freq_select,
	input wire logic [11:0] refclk_ratio
);
	logic b1, b2;
	// bit clock history: a sync change may trail its bit clock edge by one cycle
	always_ff @(posedge ref_clk) begin
		b1 <= bclk_out;
		b2 <= b1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_bclk_oe_mode: assert property (bclk_oe == master_mode)
		else $error("bit clock enable differs from mode");
	a_frame_sync_oe_mode: assert property (frame_sync_oe == master_mode)
		else $error("sync enable differs from mode");
	a_pll_root_pll: assert property (pll_enable |-> root_src == ACM_ROOT_PLL)
		else $error("root not pll while pll enabled");
	a_bypass_root_sel: assert property (!pll_enable |-> root_src != ACM_ROOT_PLL)
		else $error("root on pll while bypassed");
	a_ratio_legal: assert property (refclk_ratio inside {12'h040, 12'h100,
		12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900})
		else $error("reference ratio off table");
	a_reset_state: assert property ($rose(rst_n) |-> refclk_ratio == 12'h180
		&& !master_mode && pll_enable && refclk_freq_select == 3'h2)
		else $error("wrong state after reset");
	a_sync_on_edge: assert property (master_mode && $changed(frame_sync_out)
		|-> (b1 != bclk_out) || (b2 != b1))
		else $error("sync changed away from a bit clock edge");
	a_sync_held: assert property ($rose(frame_sync_out) |-> frame_sync_out [*2])
		else $error("sync pulse shorter than a bit");
endmodule : acm_checker
bind acm_clock_config_monitor acm_checker chk_u (.ref_clk, .rst_n, .bclk_out,
	.bclk_oe, .frame_sync_out, .frame_sync_oe, .master_mode, .pll_enable, .root_src,
	.refclk_freq_select, .refclk_ratio);

/* acm_clock_config_monitor_tb.sv */
`timescale 1ns/10ps
module acm_clock_config_monitor_tb;
	import acm_pkg::*;
	localparam logic [6:0] DEV = 7'h2a; // arbitrary bus address
	localparam logic [11:0] RT [8] = '{12'h040, 12'h100, 12'h180, 12'h200,
		12'h300, 12'h400, 12'h600, 12'h900};
	logic ref_clk, rst_n, scl, sda_h, src_en, src_b, src_f, ack;
	logic sda_out, sda_oe, bclk_out, bclk_oe, frame_sync_out, frame_sync_oe;
	logic master_mode, pll_enable, refclk_by_ratio;
	logic [2:0] refclk_freq_select;
	logic [11:0] refclk_ratio, src_ratio;
	logic [7:0] q;
	acm_root_t root_src;
	int failures, total_checks;
	int cyc = 0;
	wire logic sda_w = sda_h & !(sda_oe && !sda_out);
	wire logic bclk_w = bclk_oe ? bclk_out : src_b;
	wire logic fs_w = frame_sync_oe ? frame_sync_out : src_f;
	acm_clock_config_monitor #(.REF_CLK_HZ(50000000), .DEV_ADDR(DEV)) dut_u (
		.ref_clk, .rst_n, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe,
		.bclk_in(bclk_w), .bclk_out, .bclk_oe, .frame_sync_in(fs_w), .frame_sync_out,
		.frame_sync_oe, .master_mode, .pll_enable, .root_src, .refclk_by_ratio,
		.refclk_freq_select, .refclk_ratio);
	acm_bus_src src_u (.en(src_en), .ratio(src_ratio), .bclk(src_b), .frame_sync(src_f));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : w
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		if (failures == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	// data moves only with scl low; low time 12 cycles, high 10
	task automatic bit_io(input logic b, output logic r);
		sda_h <= b;
		w(10);
		scl <= 1'b1;
		w(5);
		r = sda_w;
		w(5);
		scl <= 1'b0;
		w(2);
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(nack, ack);
	endtask : byte_io
	task automatic start();
		sda_h <= 1'b1;
		w(10);
		scl <= 1'b1;
		w(10);
		sda_h <= 1'b0;
		w(10);
		scl <= 1'b0;
		w(2);
	endtask : start
	task automatic stop();
		sda_h <= 1'b0;
		w(10);
		scl <= 1'b1;
		w(10);
		sda_h <= 1'b1;
		w(10);
	endtask : stop
	task automatic addr_ptr(input logic [7:0] a);
		start();
		byte_io({DEV, 1'b0}, 1'b1);
		chk(12'(ack), 12'h0);
		byte_io(a, 1'b1);
		chk(12'(ack), 12'h0);
	endtask : addr_ptr
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		addr_ptr(a);
		byte_io(d, 1'b1);
		chk(12'(ack), 12'h0);
		stop();
	endtask : reg_wr
	// final byte is refused by the host so the device lets go of the line
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		addr_ptr(a);
		start();
		byte_io({DEV, 1'b1}, 1'b1);
		chk(12'(ack), 12'h0);
		byte_io(8'hff, 1'b1);
		stop();
		chk(12'(q), 12'(exp));
	endtask : reg_rd
	// one generated frame: bit clock rises counted, level at the sync rise kept
	task automatic frame(input logic inv);
		logic pf, pb, lv;
		int n, i;
		n = 0;
		i = 0;
		pf = 1'b1;
		while (i < 3000 && !(pf === 1'b0 && frame_sync_out === 1'b1)) begin
			pf = frame_sync_out;
			@(negedge ref_clk);
			i++;
		end
		lv = bclk_out;
		pf = 1'b1;
		while (i < 6000 && !(pf === 1'b0 && frame_sync_out === 1'b1)) begin
			pf = frame_sync_out;
			pb = bclk_out;
			@(negedge ref_clk);
			i++;
			if (pb === 1'b0 && bclk_out === 1'b1) n++;
		end
		chk(12'(n), 12'd32);
		chk(12'(lv), 12'(inv));
		@(posedge ref_clk);
	endtask : frame
	// cut a hang short
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			failures++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		scl = 1'b1;
		sda_h = 1'b1;
		src_en = 1'b0;
		src_ratio = 12'd64;
		w(20);
		rst_n <= 1'b1;
		w(5);
		reg_rd(ADDR_MST_CFG, 8'h02);
		reg_rd(ADDR_RATE_CFG, 8'h48);
		reg_rd(ADDR_STATUS, 8'hff);
		reg_rd(ADDR_ROOT_CLOCK_SOURCE_CONFIG, 8'h10);
		reg_rd(8'h40, 8'h00);
		// top codes of both fields; status refuses writes
		reg_wr(ADDR_RATE_CFG, 8'h8c);
		reg_rd(ADDR_RATE_CFG, 8'h8c);
		reg_wr(ADDR_STATUS, 8'h00);
		reg_rd(ADDR_STATUS, 8'hff);
		// slave: status follows each change of frame shape, 15 when off table
		src_en <= 1'b1;
		w(1800);
		reg_rd(ADDR_STATUS, 8'h54);
		src_ratio <= 12'd32;
		w(1200);
		reg_rd(ADDR_STATUS, 8'h62);
		src_ratio <= 12'd20;
		w(600);
		reg_rd(ADDR_STATUS, 8'hff);
		// leave the bus on a valid shape so the silent-bus fallback is seen
		src_ratio <= 12'd32;
		w(800);
		src_en <= 1'b0;
		// auto mode off keeps the pll whatever the bypass bit says
		reg_wr(ADDR_MST_CFG, 8'h65);
		chk(12'(pll_enable), 12'h1);
		chk(12'(root_src), 12'(ACM_ROOT_PLL));
		// pll bypassed in slave auto mode
		reg_wr(ADDR_MST_CFG, 8'h25);
		chk(12'(pll_enable), 12'h0);
		chk(12'(root_src), 12'(ACM_ROOT_BITCLK));
		chk(12'(refclk_freq_select), 12'h5);
		for (int k = 0; k < 8; k++) begin
			reg_wr(ADDR_ROOT_CLOCK_SOURCE_CONFIG, {2'b11, 3'(k), 3'b000});
			chk(12'(root_src), 12'(ACM_ROOT_REFCLK));
			chk(12'(refclk_by_ratio), 12'h1);
			chk(refclk_ratio, RT[k]);
		end
		reg_rd(ADDR_ROOT_CLOCK_SOURCE_CONFIG, 8'hf8);
		reg_wr(ADDR_ROOT_CLOCK_SOURCE_CONFIG, 8'h10);
		chk(12'(refclk_by_ratio), 12'h0);
		// no frame for a long time: status falls back to invalid
		reg_rd(ADDR_STATUS, 8'hff);
		// master with a reserved rate code keeps the bus clocks still
		reg_wr(ADDR_RATE_CFG, 8'h92);
		reg_wr(ADDR_MST_CFG, 8'h80);
		chk(12'({bclk_oe, frame_sync_oe}), 12'h3);
		chk(12'({bclk_out, frame_sync_out}), 12'h0);
		w(1);
		chk(12'({bclk_out, frame_sync_out}), 12'h0);
		// gated master stays still with legal codes too
		reg_wr(ADDR_MST_CFG, 8'h90);
		reg_wr(ADDR_RATE_CFG, 8'h42);
		chk(12'({bclk_out, frame_sync_out}), 12'h0);
		w(16);
		chk(12'({bclk_out, frame_sync_out}), 12'h0);
		// master at 48k, 32 bits a frame; invert moves the sync edge
		reg_wr(ADDR_MST_CFG, 8'h80);
		frame(1'b0);
		reg_wr(ADDR_ROOT_CLOCK_SOURCE_CONFIG, 8'h12);
		frame(1'b1);
		reg_rd(ADDR_STATUS, 8'h42);
		reg_wr(ADDR_MST_CFG, 8'h00);
		chk(12'({bclk_oe, frame_sync_oe}), 12'h0);
		results();
	end
endmodule : acm_clock_config_monitor_tb
